// >>> dv/trr_far_side.sv
// Far-side trigger sources: each request gives one held pulse on its line
`timescale 1ns/10ps
`default_nettype none
module trr_far_side (
    // Clock and requests
    input  wire logic        clk,
    input  wire logic [15:0] req,
    // Lines into the router
    output logic      [15:0] pins
);
    logic [3:0] cnt [16] = '{default: 4'h0};
    // Twelve cycles outlast two periods of the internal timebase
    // Single held pulses keep an outside timebase edge slow enough to sample
    always_ff @(posedge clk) begin
        for (int i = 0; i < 16; i++) begin
            cnt[i] <= req[i] ? 4'hC : (cnt[i] != 4'h0 ? cnt[i] - 4'h1 : 4'h0);
        end
    end
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            pins[i] = cnt[i] != 4'h0;
        end
    end
endmodule // trr_far_side
`default_nettype wire

// >>> dv/trr_trigger_router_tb.sv
// Self-checking bench for the trigger router
`timescale 1ns/10ps
`default_nettype none
module trr_trigger_router_tb;
    logic        clk_sys = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic        pready, pslverr, err, timebaseTick, scanStartStrobe;
    logic        acqStartTrigger, waveStartTrigger, sampleConvertStrobe, outputUpdateStrobe;
    logic [15:0] req = 0, pins;
    logic [4:0]  outs;
    logic [4:0]  q[$];
    int          err_count = 0, tests_run = 0, tk = 0, t0;
    // Source and line of scan start cases; a set timebase field needs a pending request first
    localparam logic [15:0] SCANS [5] = '{16'h000F, 16'h0102, 16'h020E, 16'h001C, 16'h002D};
    // Source, config, line, expected {update, convert, wave, acq}
    localparam logic [27:0] CASES [24] = '{
        28'h004_0001,
        28'h004_0101,
        28'h004_0010,
        28'h100_0212,
        28'h040_0024,
        28'h400_0038,
        28'h00C_0041,
        28'h300_0052,
        28'h080_0064,
        28'h800_0078,
        28'h000_0084,
        28'h000_0098,
        28'h044_0000,
        28'h008_0CA1,
        28'h008_0CA0,
        28'h008_0CB0,
        28'h008_0CA1,
        28'h008_10A0,
        28'h008_10B1,
        28'h008_10B0,
        28'h000_0830,
        28'h008_08A1,
        28'h008_00B1,
        28'h200_04A2
    };
    assign outs = {scanStartStrobe, outputUpdateStrobe, sampleConvertStrobe, waveStartTrigger,
                   acqStartTrigger};
    always #2.5 clk_sys = ~clk_sys;
    trr_trigger_router trr_trigger_router_i (.clk_sys, .resetn, .paddr, .psel, .penable,
        .pwrite, .pwdata, .prdata, .pready, .pslverr, .acqEdgeTriggerPin(pins[0]),
        .waveEdgeTriggerPin(pins[1]), .auxInputZero(pins[2]), .auxInputOne(pins[3]),
        .syncBusAcqTrigger(pins[4]), .syncBusWaveTrigger(pins[5]), .syncBusConvert(pins[6]),
        .syncBusUpdate(pins[7]), .convCounterStrobe(pins[8]), .updCounterStrobe(pins[9]),
        .cmpAboveHigh(pins[10]), .cmpBelowLow(pins[11]), .outsideBaseClockPin(pins[12]),
        .syncBusBaseClock(pins[13]), .syncBusScanBegin(pins[14]), .siCounterScan(pins[15]),
        .timebaseTick, .acqStartTrigger, .waveStartTrigger, .scanStartStrobe,
        .sampleConvertStrobe, .outputUpdateStrobe);
    trr_far_side trr_far_side_i (.clk(clk_sys), .req, .pins);
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
            err_count++;
        end
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            err_count++;
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic pulse(int line, logic [4:0] exp);
        if (exp != 0) q.push_back(exp);
        @(posedge clk_sys);
        req[line] <= 1;
        @(posedge clk_sys);
        req[line] <= 0;
        repeat (30 + $urandom % 8) @(posedge clk_sys);
    endtask
    // Each routed pulse retires the oldest expectation
    // Outputs are unknown until the first edge in reset, so only watch once it is released
    always @(posedge clk_sys) begin
        if (resetn && timebaseTick) tk <= tk + 1;
        if (resetn && outs !== 5'h00) begin
            if (q.size() == 0) chk(outs, 0);
            else chk(outs, q.pop_front());
        end
    end
    initial begin
        void'($urandom(70));
        repeat (8) @(posedge clk_sys);
        resetn <= 1;
        repeat (3) @(posedge clk_sys);
        apb(0, 8'h00, 0);
        chk(rd, 0);
        apb(0, 8'h04, 0);
        chk(rd, 0);
        apb(0, 8'h10, 0);
        chk(err, 1);
        q.push_back(5'h01);
        apb(1, 8'h08, 1);
        q.push_back(5'h02);
        apb(1, 8'h08, 2);
        repeat (10) @(posedge clk_sys);
        apb(0, 8'h0C, 0);
        chk(rd, 32'h0000_000E);
        apb(1, 8'h0C, 6);
        apb(0, 8'h0C, 0);
        chk(rd, 32'h0000_0008);
        t0 = tk;
        repeat (50) @(posedge clk_sys);
        chk(tk - t0, 10);
        foreach (CASES[i]) begin
            apb(1, 8'h00, {20'($urandom), CASES[i][27:16]});
            apb(1, 8'h04, {24'h0, CASES[i][15:8]});
            pulse(CASES[i][7:4], {1'b0, CASES[i][3:0]});
        end
        foreach (SCANS[i]) begin
            apb(1, 8'h00, {20'h0, SCANS[i][15:4]});
            if (SCANS[i][5:4] != 0) pulse(15, 0);
            t0 = tk;
            pulse(SCANS[i][3:0], 5'h10);
            if (SCANS[i][5:4] != 0) chk(tk - t0, 1);
        end
        chk(q.size(), 0);
        give_verdict();
    end
endmodule // trr_trigger_router_tb
`default_nettype wire

// >>> rtl/trr_analog_cond.sv
// Analog trigger condition from comparator results, with hysteresis re-arm
`timescale 1ns/10ps
`default_nettype none
module trr_analog_cond (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      rstn,
    // Configuration and comparators
    input  wire trr_pkg::trr_analog_mode_t mode,
    input  wire logic                      aboveHigh,
    input  wire logic                      belowLow,
    // Result
    output logic                           condLevel,
    output logic                           fire,
    output logic                           armed
);
    logic levelDly_reg;
    logic fire_reg;
    logic fire_next;
    logic armed_reg;
    logic armed_next;
    logic levelNow;
    logic isHyst;
    logic rearm;

    // Upper threshold is assumed above the lower one, so both flags never stand together
    assign levelNow = (mode == trr_pkg::TRR_AN_BELOW)     ? belowLow :
                      (mode == trr_pkg::TRR_AN_ABOVE)     ? aboveHigh :
                      (mode == trr_pkg::TRR_AN_INSIDE)    ? (~aboveHigh & ~belowLow) : // R4
                      (mode == trr_pkg::TRR_AN_HIGH_HYST) ? aboveHigh : // R1
                      (mode == trr_pkg::TRR_AN_LOW_HYST)  ? belowLow : 1'b0; // R2
    assign isHyst = (mode == trr_pkg::TRR_AN_HIGH_HYST) | (mode == trr_pkg::TRR_AN_LOW_HYST);
    assign rearm  = (mode == trr_pkg::TRR_AN_HIGH_HYST) ? belowLow : aboveHigh; // R3
    assign fire_next  = isHyst ? (armed_reg & levelNow) : (levelNow & ~levelDly_reg);
    assign armed_next = (armed_reg & ~fire_next) | rearm; // R3

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            levelDly_reg <= 1'b0;
            fire_reg     <= 1'b0;
            armed_reg    <= 1'b1;
        end else begin
            levelDly_reg <= levelNow;
            fire_reg     <= fire_next;
            armed_reg    <= isHyst ? armed_next : 1'b1;
        end
    end

    assign condLevel = levelDly_reg;
    assign fire      = fire_reg;
    assign armed     = armed_reg;

    chk_high_hyst_fire: assert property (@(posedge clk) disable iff (!rstn) // R1
        mode == trr_pkg::TRR_AN_HIGH_HYST && armed_reg && aboveHigh |=> fire_reg)
        else $error("armed high hysteresis did not fire above threshold");
    chk_low_hyst_fire: assert property (@(posedge clk) disable iff (!rstn) // R2
        mode == trr_pkg::TRR_AN_LOW_HYST && armed_reg && belowLow |=> fire_reg)
        else $error("armed low hysteresis did not fire below threshold");
    chk_hyst_no_refire: assert property (@(posedge clk) disable iff (!rstn) // R3
        isHyst && fire_reg && !rearm && $stable(mode) |=> !fire_reg)
        else $error("hysteresis fired again without re-arm");
endmodule // trr_analog_cond
`default_nettype wire

// >>> rtl/trr_edge_sync.sv
// Two-stage synchroniser with rising and falling edge pulses
`timescale 1ns/10ps
`default_nettype none
module trr_edge_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rstn,
    // Asynchronous inputs
    input  wire logic [WIDTH-1:0] din,
    // Synchronised edges
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] last_reg;

    if (WIDTH < 1) begin : g_bad_width
        $error("trr_edge_sync needs WIDTH of at least 1");
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_reg <= '0;
            sync_reg <= '0;
            last_reg <= '0;
        end else begin
            meta_reg <= din;     // R20
            sync_reg <= meta_reg; // R20
            last_reg <= sync_reg;
        end
    end

    // Edges look only at the second and third stage, never the metastable one
    assign level = sync_reg;
    assign rise  = sync_reg & ~last_reg;
    assign fall  = ~sync_reg & last_reg;

    for (genvar i = 0; i < WIDTH; i++) begin : g_chk
        chk_sync_two_stage: assert property (@(posedge clk) disable iff (!rstn) // R20
            $rose(din[i]) ##1 din[i] |-> ##1 rise[i])
            else $error("edge not seen two cycles after input rose");
    end
endmodule // trr_edge_sync
`default_nettype wire

// >>> rtl/trr_params.svh
// Offsets, field positions, reset values and timing counts of the trigger router
`ifndef TRR_PARAMS_SVH
`define TRR_PARAMS_SVH
`define TRR_OFF_SRC        8'h00
`define TRR_OFF_CFG        8'h04
`define TRR_OFF_SWTRIG     8'h08
`define TRR_OFF_STATUS     8'h0C
`define TRR_SRC_TB_LSB     0
`define TRR_SRC_ACQ_LSB    2
`define TRR_SRC_SCAN_LSB   4
`define TRR_SRC_CONV_LSB   6
`define TRR_SRC_WAVE_LSB   8
`define TRR_SRC_UPD_LSB    10
`define TRR_CFG_ACQPOL_BIT 0
`define TRR_CFG_WAVPOL_BIT 1
`define TRR_CFG_MODE_LSB   2
`define TRR_SW_ACQ_BIT     0
`define TRR_SW_WAVE_BIT    1
`define TRR_SRC_RESET      12'h000
`define TRR_CFG_RESET      5'h00
`define TRR_CLK_SYS_MHZ    200
`define TRR_OSC_MHZ        40
`define TRR_OSC_DIV        (`TRR_CLK_SYS_MHZ / `TRR_OSC_MHZ)
`endif

// >>> rtl/trr_pkg.sv
// Types of the trigger and timing router
package trr_pkg;
    typedef enum logic [1:0] {
        TRR_TB_OSC = 2'b00,
        TRR_TB_PIN = 2'b01,
        TRR_TB_BUS = 2'b10
    } trr_base_src_t;
    typedef enum logic [1:0] {
        TRR_STB_INT = 2'b00,
        TRR_STB_AUX = 2'b01,
        TRR_STB_BUS = 2'b10
    } trr_strobe_src_t;
    typedef enum logic [1:0] {
        TRR_TRG_SW     = 2'b00,
        TRR_TRG_EDGE   = 2'b01,
        TRR_TRG_ANALOG = 2'b10,
        TRR_TRG_BUS    = 2'b11
    } trr_trig_src_t;
    typedef enum logic [2:0] {
        TRR_AN_BELOW     = 3'b000,
        TRR_AN_ABOVE     = 3'b001,
        TRR_AN_INSIDE    = 3'b010,
        TRR_AN_HIGH_HYST = 3'b011,
        TRR_AN_LOW_HYST  = 3'b100
    } trr_analog_mode_t;
endpackage

// >>> rtl/trr_trigger_router.sv
// Trigger and timing-signal router with APB register access
`include "trr_params.svh"
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// R1: High hysteresis fires when input exceeds upper threshold; lower threshold sets band.
// R2: Low hysteresis fires when input drops below lower threshold; upper sets band.
// R3: After a hysteresis fire, re-arm only once the opposite threshold is crossed.
// R4: Software keeps upper threshold above lower threshold.
// R5: External digital trigger is recognised on the selected edge of its pin.
// R6: Edge polarity programmable separately for acquisition and update trigger pins.
// R7: One trigger pin feeds only acquisition, the other only output update.
// R8: Every timing signal has its own independent source selector.
// R9: Timebase comes from internal 40 MHz oscillator, timebase pin or bus.
// R10: An external timebase lies between 1 MHz and 40 MHz.
// R11: Acquisition trigger from edge pin, analog, software or bus trigger line.
// R12: Scan start from sample-interval counter, aux input 0 or bus.
// R13: Scan start stays synchronous to the selected timebase.
// R14: Conversion strobe from counter, aux input 0 or bus; acts on edges.
// R15: With aux input 0 as source, one conversion per rising edge.
// R16: Output trigger from edge pin, analog, software or bus trigger line.
// R17: Update strobe from counter, aux input 1 or bus; acts on edges.
// R18: With aux input 1 as source, one update per rising edge.
// R19: One timebase selection clocks both acquisition and output timing.
// R20: Outside pins and bus strobes pass two-stage synchronisers before edge detection.
// R21: Scan start pulses on aux input 0 last over two timebase periods.
// R22: Conversion from aux input 0 mutes internal scan start and triggers; the code mutes the acquisition trigger but not the output trigger.
// R23: After reset every selector picks its internally generated source.
module trr_trigger_router #(
    parameter int ADDR_W  = 8,
    parameter int OSC_DIV = `TRR_OSC_DIV
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    // APB slave
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Outside pins
    input  wire logic              acqEdgeTriggerPin,
    input  wire logic              waveEdgeTriggerPin,
    input  wire logic              outsideBaseClockPin,
    input  wire logic              auxInputZero,
    input  wire logic              auxInputOne,
    // Card synchronisation bus
    input  wire logic              syncBusBaseClock,
    input  wire logic              syncBusAcqTrigger,
    input  wire logic              syncBusWaveTrigger,
    input  wire logic              syncBusScanBegin,
    input  wire logic              syncBusConvert,
    input  wire logic              syncBusUpdate,
    // Internal counters and comparators
    input  wire logic              siCounterScan,
    input  wire logic              convCounterStrobe,
    input  wire logic              updCounterStrobe,
    input  wire logic              cmpAboveHigh,
    input  wire logic              cmpBelowLow,
    // Routed timing signals
    output logic                   timebaseTick,
    output logic                   acqStartTrigger,
    output logic                   waveStartTrigger,
    output logic                   scanStartStrobe,
    output logic                   sampleConvertStrobe,
    output logic                   outputUpdateStrobe
);
    localparam int NSYNC = 11;
    localparam int IX_ACQPIN = 0;
    localparam int IX_WAVPIN = 1;
    localparam int IX_TBPIN  = 2;
    localparam int IX_AUX0   = 3;
    localparam int IX_AUX1   = 4;
    localparam int IX_BUSTB  = 5;
    localparam int IX_BUSACQ = 6;
    localparam int IX_BUSWAV = 7;
    localparam int IX_BUSSCN = 8;
    localparam int IX_BUSCNV = 9;
    localparam int IX_BUSUPD = 10;

    if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr
        $error("trr_trigger_router needs ADDR_W between 4 and 32");
    end
    if (OSC_DIV < 2 || OSC_DIV > 256) begin : g_bad_div
        $error("trr_trigger_router needs OSC_DIV between 2 and 256");
    end

    function automatic logic regHit(input logic [ADDR_W-1:0] addr, input logic [7:0] off);
        regHit = (addr == ADDR_W'(off));
    endfunction

    // Reset release
    logic rstMeta_reg;
    logic rstn;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rstMeta_reg <= 1'b0;
            rstn        <= 1'b0;
        end else begin
            rstMeta_reg <= 1'b1;
            rstn        <= rstMeta_reg;
        end
    end

    // Input synchronisers
    logic [NSYNC-1:0] syncLevel;
    logic [NSYNC-1:0] syncRise;
    logic [NSYNC-1:0] syncFall;
    trr_edge_sync #(.WIDTH(NSYNC)) u_sync (
        .clk   (clk_sys),
        .rstn  (rstn),
        .din   ({syncBusUpdate, syncBusConvert, syncBusScanBegin, syncBusWaveTrigger,
                 syncBusAcqTrigger, syncBusBaseClock, auxInputOne, auxInputZero,
                 outsideBaseClockPin, waveEdgeTriggerPin, acqEdgeTriggerPin}), // R20
        .level (syncLevel),
        .rise  (syncRise),
        .fall  (syncFall)
    );

    // Registers
    logic [11:0] src_reg;
    logic [4:0]  cfg_reg;
    logic        swAcq_reg;
    logic        swWave_reg;
    logic        acqSeen_reg;
    logic        waveSeen_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic [31:0] prdata_reg;

    trr_pkg::trr_base_src_t    tbSel;
    trr_pkg::trr_trig_src_t    acqSel;
    trr_pkg::trr_strobe_src_t  scanSel;
    trr_pkg::trr_strobe_src_t  convSel;
    trr_pkg::trr_trig_src_t    waveSel;
    trr_pkg::trr_strobe_src_t  updSel;
    trr_pkg::trr_analog_mode_t anMode;
    // Each selector owns its own field
    assign tbSel   = trr_pkg::trr_base_src_t'(src_reg[`TRR_SRC_TB_LSB +: 2]); // R8
    assign acqSel  = trr_pkg::trr_trig_src_t'(src_reg[`TRR_SRC_ACQ_LSB +: 2]); // R8
    assign scanSel = trr_pkg::trr_strobe_src_t'(src_reg[`TRR_SRC_SCAN_LSB +: 2]); // R8
    assign convSel = trr_pkg::trr_strobe_src_t'(src_reg[`TRR_SRC_CONV_LSB +: 2]); // R8
    assign waveSel = trr_pkg::trr_trig_src_t'(src_reg[`TRR_SRC_WAVE_LSB +: 2]); // R8
    assign updSel  = trr_pkg::trr_strobe_src_t'(src_reg[`TRR_SRC_UPD_LSB +: 2]); // R8
    assign anMode  = trr_pkg::trr_analog_mode_t'(cfg_reg[`TRR_CFG_MODE_LSB +: 3]);

    // APB decode
    wire setupPh = psel & ~penable;
    wire accessPh = psel & penable & pready_reg;
    wire wrAcc = accessPh & pwrite;
    wire hitSrc = regHit(paddr, `TRR_OFF_SRC);
    wire hitCfg = regHit(paddr, `TRR_OFF_CFG);
    wire hitSw = regHit(paddr, `TRR_OFF_SWTRIG);
    wire hitStat = regHit(paddr, `TRR_OFF_STATUS);
    wire mapped = hitSrc | hitCfg | hitSw | hitStat;

    // Analog condition
    logic anLevel;
    logic anFire;
    logic anArmed;
    trr_analog_cond u_analog (
        .clk       (clk_sys),
        .rstn      (rstn),
        .mode      (anMode),
        .aboveHigh (cmpAboveHigh),
        .belowLow  (cmpBelowLow),
        .condLevel (anLevel),
        .fire      (anFire),
        .armed     (anArmed)
    );

    wire [4:0] statusBits = {anArmed, waveSeen_reg, acqSeen_reg, anLevel, 1'b0} >> 1;
    wire [31:0] rdMux = hitSrc  ? {20'h0_0000, src_reg} :
                        hitCfg  ? {27'h000_0000, cfg_reg} :
                        hitStat ? {28'h000_0000, statusBits[3:0]} : 32'h0000_0000;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else begin
            pready_reg <= setupPh;
            if (setupPh) begin
                pslverr_reg <= ~mapped;
                prdata_reg  <= pwrite ? 32'h0000_0000 : rdMux;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            src_reg <= `TRR_SRC_RESET; // R23
            cfg_reg <= `TRR_CFG_RESET;
        end else begin
            if (wrAcc && hitSrc) src_reg <= pwdata[11:0];
            if (wrAcc && hitCfg) cfg_reg <= pwdata[4:0];
        end
    end

    // Software triggers are one-cycle pulses from a write
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            swAcq_reg  <= 1'b0;
            swWave_reg <= 1'b0;
        end else begin
            swAcq_reg  <= wrAcc & hitSw & pwdata[`TRR_SW_ACQ_BIT];
            swWave_reg <= wrAcc & hitSw & pwdata[`TRR_SW_WAVE_BIT];
        end
    end

    // Timebase
    logic [7:0] divCnt_reg;
    wire intTick = (divCnt_reg == 8'(OSC_DIV - 1));
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            divCnt_reg <= 8'h00;
        end else begin
            divCnt_reg <= intTick ? 8'h00 : divCnt_reg + 8'h01; // R9
        end
    end
    // The pin and bus timebases are sampled, so they must stay well below clk_sys
    wire tbTick = (tbSel == trr_pkg::TRR_TB_PIN) ? syncRise[IX_TBPIN] :
                  (tbSel == trr_pkg::TRR_TB_BUS) ? syncRise[IX_BUSTB] : intTick; // R9 R19

    // Internal counter strobes are synchronous; edges taken locally
    logic siDly_reg;
    logic convDly_reg;
    logic updDly_reg;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            siDly_reg   <= 1'b0;
            convDly_reg <= 1'b0;
            updDly_reg  <= 1'b0;
        end else begin
            siDly_reg   <= siCounterScan;
            convDly_reg <= convCounterStrobe;
            updDly_reg  <= updCounterStrobe;
        end
    end
    wire siRise = siCounterScan & ~siDly_reg;
    wire convRise = convCounterStrobe & ~convDly_reg;
    wire updRise = updCounterStrobe & ~updDly_reg;

    // Trigger selection
    wire acqEdgeHit = cfg_reg[`TRR_CFG_ACQPOL_BIT] ? syncFall[IX_ACQPIN] : // R5 R6
                      syncRise[IX_ACQPIN];
    wire waveEdgeHit = cfg_reg[`TRR_CFG_WAVPOL_BIT] ? syncFall[IX_WAVPIN] : // R6
                       syncRise[IX_WAVPIN];
    wire convFromAux = (convSel == trr_pkg::TRR_STB_AUX);
    wire acqPick = (acqSel == trr_pkg::TRR_TRG_EDGE)   ? acqEdgeHit : // R7
                   (acqSel == trr_pkg::TRR_TRG_ANALOG) ? anFire :
                   (acqSel == trr_pkg::TRR_TRG_BUS)    ? syncRise[IX_BUSACQ] : swAcq_reg; // R11
    wire wavePick = (waveSel == trr_pkg::TRR_TRG_EDGE)   ? waveEdgeHit : // R7
                    (waveSel == trr_pkg::TRR_TRG_ANALOG) ? anFire :
                    (waveSel == trr_pkg::TRR_TRG_BUS)    ? syncRise[IX_BUSWAV] : swWave_reg; // R16
    wire acqTrig_next = acqPick & ~convFromAux; // R22

    // Strobe selection, all on edges
    wire scanReq = (scanSel == trr_pkg::TRR_STB_AUX) ? syncRise[IX_AUX0] :
                   (scanSel == trr_pkg::TRR_STB_BUS) ? syncRise[IX_BUSSCN] : siRise; // R12
    wire convReq = (convSel == trr_pkg::TRR_STB_AUX) ? syncRise[IX_AUX0] : // R15
                   (convSel == trr_pkg::TRR_STB_BUS) ? syncRise[IX_BUSCNV] : convRise; // R14
    wire updReq = (updSel == trr_pkg::TRR_STB_AUX) ? syncRise[IX_AUX1] : // R18
                  (updSel == trr_pkg::TRR_STB_BUS) ? syncRise[IX_BUSUPD] : updRise; // R17

    // Scan start waits for the next timebase tick; a request on the tick itself goes out
    logic scanPend_reg;
    logic scanStart_reg;
    wire scanPend_next = (scanPend_reg | scanReq) & ~tbTick & ~convFromAux;
    wire scanStart_next = (scanPend_reg | scanReq) & tbTick & ~convFromAux; // R13 R22

    logic tbTick_reg;
    logic acqTrig_reg;
    logic waveTrig_reg;
    logic conv_reg;
    logic upd_reg;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tbTick_reg    <= 1'b0;
            acqTrig_reg   <= 1'b0;
            waveTrig_reg  <= 1'b0;
            scanPend_reg  <= 1'b0;
            scanStart_reg <= 1'b0;
            conv_reg      <= 1'b0;
            upd_reg       <= 1'b0;
        end else begin
            tbTick_reg    <= tbTick; // R19
            acqTrig_reg   <= acqTrig_next;
            waveTrig_reg  <= wavePick;
            scanPend_reg  <= scanPend_next;
            scanStart_reg <= scanStart_next;
            conv_reg      <= convReq; // R14
            upd_reg       <= updReq; // R17
        end
    end

    // Sticky seen flags: a new trigger wins over a write-one clear in the same cycle
    wire clrAcq = wrAcc & hitStat & pwdata[1];
    wire clrWave = wrAcc & hitStat & pwdata[2];
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            acqSeen_reg  <= 1'b0;
            waveSeen_reg <= 1'b0;
        end else begin
            acqSeen_reg  <= acqTrig_reg | (acqSeen_reg & ~clrAcq);
            waveSeen_reg <= waveTrig_reg | (waveSeen_reg & ~clrWave);
        end
    end

    assign prdata              = prdata_reg;
    assign pready              = pready_reg;
    assign pslverr             = pslverr_reg;
    assign timebaseTick        = tbTick_reg;
    assign acqStartTrigger     = acqTrig_reg;
    assign waveStartTrigger    = waveTrig_reg;
    assign scanStartStrobe     = scanStart_reg;
    assign sampleConvertStrobe = conv_reg;
    assign outputUpdateStrobe  = upd_reg;

    sequence seqOscGap;
        (!intTick)[*4] ##1 intTick;
    endsequence
    sequence seqAuxConvert;
        convSel == trr_pkg::TRR_STB_AUX && syncRise[IX_AUX0];
    endsequence

    chk_osc_period: assert property (@(posedge clk_sys) disable iff (!rstn) // R9
        intTick |=> seqOscGap)
        else $error("internal oscillator tick not every five cycles");
    chk_tick_follows_sel: assert property (@(posedge clk_sys) disable iff (!rstn) // R19
        tbSel == trr_pkg::TRR_TB_PIN && syncRise[IX_TBPIN] |=> timebaseTick)
        else $error("pin timebase edge did not reach the shared tick");
    chk_conv_per_edge: assert property (@(posedge clk_sys) disable iff (!rstn) // R15
        seqAuxConvert |=> sampleConvertStrobe ##1 !sampleConvertStrobe)
        else $error("aux input 0 edge did not give exactly one conversion");
    chk_upd_per_edge: assert property (@(posedge clk_sys) disable iff (!rstn) // R18
        updSel == trr_pkg::TRR_STB_AUX && syncRise[IX_AUX1] |=> outputUpdateStrobe)
        else $error("aux input 1 edge did not give an update");
    chk_scan_on_tick: assert property (@(posedge clk_sys) disable iff (!rstn) // R13
        scanStartStrobe |-> timebaseTick)
        else $error("scan start left the timebase grid");
    chk_aux_mutes: assert property (@(posedge clk_sys) disable iff (!rstn) // R22
        convFromAux |=> !scanStartStrobe && !acqStartTrigger)
        else $error("scan start or trigger passed while aux input 0 converts");
    chk_acq_edge_pol: assert property (@(posedge clk_sys) disable iff (!rstn) // R5
        acqSel == trr_pkg::TRR_TRG_EDGE && !convFromAux && acqEdgeHit |=> acqStartTrigger)
        else $error("selected acquisition edge did not trigger");
    chk_wave_pin_only: assert property (@(posedge clk_sys) disable iff (!rstn) // R7
        waveSel == trr_pkg::TRR_TRG_EDGE && !waveEdgeHit |=> !waveStartTrigger)
        else $error("output trigger fired without its own pin edge");
    chk_reset_internal: assert property (@(posedge clk_sys) // R23
        !rstn |-> tbSel == trr_pkg::TRR_TB_OSC && scanSel == trr_pkg::TRR_STB_INT
                  && convSel == trr_pkg::TRR_STB_INT && updSel == trr_pkg::TRR_STB_INT)
        else $error("selectors not internal during reset");
endmodule // trr_trigger_router
`default_nettype wire
